//--- hw/bemfid_pkg.sv
//******************************************************************************
// BEMF event input detection - shared constants
//******************************************************************************
// Purpose: Offsets, field positions, reset values and timing for the detector
// Assumes: 32-bit APB, SYS_CLK at 200 MHz, window table based on 4 MHz clock
// Notes:   Register layout is local to this block

package bemfid_pkg;

  //****************************************************************************
  // Clocks and window timing
  //****************************************************************************
  localparam int SYS_CLK_MHZ       = 200;
  localparam int PERIPH_CLK_MHZ    = 4;
  localparam int PERIPH_DIV_CYC    = SYS_CLK_MHZ / PERIPH_CLK_MHZ;
  localparam int WIN_FINE_STEP_US  = 5;
  localparam int WIN_COARSE_BASE_US = 60;
  localparam int WIN_COARSE_STEP_US = 20;

  //****************************************************************************
  // Register offsets (byte addresses)
  //****************************************************************************
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_CFG   = 8'h04;
  localparam logic [7:0] ADDR_DFILT = 8'h08;
  localparam logic [7:0] ADDR_ZFILT = 8'h0c;
  localparam logic [7:0] ADDR_SWEVT = 8'h10;
  localparam logic [7:0] ADDR_STAT  = 8'h14;

  //****************************************************************************
  // Field positions
  //****************************************************************************
  localparam int CTRL_CKE_BIT    = 0;
  localparam int CTRL_DAC_BIT    = 1;
  localparam int CTRL_SENSOR_BIT = 2;
  localparam int CTRL_VMODE_BIT  = 3;
  localparam int CTRL_HARD_BIT   = 4;
  localparam int CFG_SEL_LSB     = 0;
  localparam int CFG_THR_LSB     = 2;
  localparam int CFG_POL_BIT     = 5;
  localparam int CFG_ZVD_BIT     = 6;
  localparam int CFG_TYPE_LSB    = 7;
  localparam int CFG_RATE_LSB    = 9;
  localparam int CFG_SCF_LSB     = 13;
  localparam int FILT_LIM_LSB    = 4;
  localparam int SWEVT_C_BIT     = 0;
  localparam int SWEVT_D_BIT     = 1;
  localparam int SWEVT_Z_BIT     = 2;

  //****************************************************************************
  // Reset values and codes
  //****************************************************************************
  localparam logic [4:0]  CTRL_RST     = 5'h10;
  localparam logic [14:0] CFG_RST      = 15'h0000;
  localparam logic [7:0]  FILT_RST     = 8'h0f;
  localparam logic [1:0]  TYPE_POS     = 2'h0;
  localparam logic [2:0]  THRESH_EXT   = 3'h7;

  typedef enum logic [2:0] {ST_WAIT_C, ST_D_BLANK, ST_D_COUNT, ST_Z_BLANK, ST_Z_COUNT} bemfid_state_t;

endpackage

//--- hw/bemfid_top.sv
//******************************************************************************
// BEMF event input detection - top
//******************************************************************************
// Purpose: Phase select, threshold select, D/Z event detection with filters
// Assumes: Comparator and phase pins asynchronous; C_EVT, PWM_SAMPLE, SIM_* local
// Notes:   One wait state on every APB access
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps

module bemfid_top import bemfid_pkg::*; #(
  parameter int PERIPH_DIV = PERIPH_DIV_CYC
) (
  input  wire  logic        SYS_CLK,
  input  wire  logic        RST_B,
  input  wire  logic        PSEL,
  input  wire  logic        PENABLE,
  input  wire  logic        PWRITE,
  input  wire  logic [7:0]  PADDR,
  input  wire  logic [31:0] PWDATA,
  output logic [31:0]       PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  input  wire  logic        COMP_OUT,
  input  wire  logic        PHASE_A,
  input  wire  logic        PHASE_B,
  input  wire  logic        PHASE_C,
  input  wire  logic        C_EVT,
  input  wire  logic        PWM_SAMPLE,
  input  wire  logic        SIM_D,
  input  wire  logic        SIM_Z,
  output logic              COMP_ON,
  output logic [1:0]        PHASE_SEL,
  output logic [2:0]        THRESH_SEL,
  output logic              EXT_REF_SEL,
  output logic              SPEED_MODE,
  output logic [2:0]        DIGITAL_PHASES,
  output logic              D_EVENT,
  output logic              Z_EVENT
);

  //****************************************************************************
  // State record
  //****************************************************************************
  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [4:0]    ctrl;
    logic [14:0]   cfg_pre;
    logic [14:0]   cfg;
    logic [7:0]    dfilt;
    logic [7:0]    zfilt;
    logic [3:0]    s1;
    logic [3:0]    s2;
    logic [3:0]    s3;
    logic [3:0]    lvl;
    logic          prev_cmp;
    bemfid_state_t state;
    logic [4:0]    cnt;
    logic [9:0]    win;
    logic [7:0]    div_cnt;
    logic [3:0]    rate_cnt;
    logic [7:0]    scf_cnt;
    logic          d_flag;
    logic          z_flag;
    logic          d_evt;
    logic          z_evt;
    logic          comp_on;
    logic          speed;
    logic          ext_ref;
  } bemfid_regs_t;

  bemfid_regs_t q;
  bemfid_regs_t n;

  logic       access;
  logic       wr_done;
  logic       soft_c;
  logic       soft_d;
  logic       soft_z;
  logic       c_ev;
  logic       sim_d;
  logic       sim_z;
  logic       periph_tick;
  logic       d_tick;
  logic       z_tick;
  logic       cmp;
  logic       d_hit;
  logic       z_hit;
  logic       active;
  logic       sensor;
  logic [4:0] d_lim;
  logic [4:0] z_lim;

  //****************************************************************************
  // Decode helpers
  //****************************************************************************
  // Window length in peripheral clock ticks
  function automatic logic [9:0] win_ticks(input logic [3:0] code);
    int us;
    if (code[3]) begin
      us = WIN_COARSE_BASE_US + int'(code[2:0]) * WIN_COARSE_STEP_US;
    end else begin
      us = (int'(code[2:0]) + 1) * WIN_FINE_STEP_US;
    end
    return 10'(us * PERIPH_CLK_MHZ);
  endfunction

  // Mapped register check
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_CFG) || (a == ADDR_DFILT) ||
           (a == ADDR_ZFILT) || (a == ADDR_SWEVT) || (a == ADDR_STAT);
  endfunction

  // Sampling clock mask: one sample every 1, 4, 16 or 256 cycles
  function automatic logic [7:0] scf_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    scf_mask = 8'h00;
      2'h1:    scf_mask = 8'h03;
      2'h2:    scf_mask = 8'h0f;
      default: scf_mask = 8'hff;
    endcase
  endfunction

  //****************************************************************************
  // Next state
  //****************************************************************************
  // Bus, timing and detection sequencer
  always_comb begin
    n = q;
    access  = PSEL & PENABLE;
    wr_done = access & q.pready & PWRITE & addr_ok(PADDR);
    soft_c  = wr_done & (PADDR == ADDR_SWEVT) & PWDATA[SWEVT_C_BIT];
    soft_d  = wr_done & (PADDR == ADDR_SWEVT) & PWDATA[SWEVT_D_BIT];
    soft_z  = wr_done & (PADDR == ADDR_SWEVT) & PWDATA[SWEVT_Z_BIT];
    c_ev    = C_EVT | soft_c;
    sim_d   = SIM_D | soft_d;
    sim_z   = SIM_Z | soft_z;
    sensor  = q.ctrl[CTRL_SENSOR_BIT];
    active  = q.comp_on & ~q.speed;
    d_lim   = sensor ? 5'd1 : 5'({1'b0, q.dfilt[FILT_LIM_LSB +: 4]}) + 5'd1;
    z_lim   = 5'({1'b0, q.zfilt[FILT_LIM_LSB +: 4]}) + 5'd1;

    // APB slave, one wait state
    n.pready  = access & ~q.pready;
    n.pslverr = access & ~q.pready & ~addr_ok(PADDR);
    n.prdata  = 32'h0;
    if (access & ~q.pready & ~PWRITE) begin
      case (PADDR)
        ADDR_CTRL:  n.prdata = {27'h0, q.ctrl};
        ADDR_CFG:   n.prdata = {17'h0, q.cfg_pre};
        ADDR_DFILT: n.prdata = {24'h0, q.dfilt};
        ADDR_ZFILT: n.prdata = {24'h0, q.zfilt};
        ADDR_STAT:  n.prdata = {26'h0, q.state == ST_Z_BLANK, q.state == ST_D_BLANK,
                                q.comp_on, q.speed, q.z_flag, q.d_flag};
        default:    n.prdata = 32'h0;
      endcase
    end
    if (wr_done) begin
      case (PADDR)
        ADDR_CTRL:  n.ctrl    = PWDATA[4:0];
        ADDR_CFG:   n.cfg_pre = PWDATA[14:0];
        ADDR_DFILT: n.dfilt   = PWDATA[7:0];
        ADDR_ZFILT: n.zfilt   = PWDATA[7:0];
        ADDR_STAT: begin
          n.d_flag = q.d_flag & ~PWDATA[0];
          n.z_flag = q.z_flag & ~PWDATA[1];
        end
        default: n.ctrl = q.ctrl;
      endcase
    end

    // Preload becomes active at C, or at once in direct access
    if (c_ev | q.ctrl[CTRL_DAC_BIT]) begin
      n.cfg = q.cfg_pre;
    end

    // Pin synchronisers, change accepted when stages two and three agree
    n.s1 = {COMP_OUT, PHASE_C, PHASE_B, PHASE_A};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.lvl[i] = q.s3[i];
      end
    end
    cmp = q.lvl[3];

    // Peripheral clock tick and sampling strobes
    periph_tick = (q.div_cnt == 8'(PERIPH_DIV - 1));
    n.div_cnt   = periph_tick ? 8'h0 : q.div_cnt + 8'h1;
    n.scf_cnt   = q.scf_cnt + 8'h1;
    d_tick      = (q.scf_cnt & scf_mask(q.cfg[CFG_SCF_LSB +: 2])) == 8'h0;
    if (periph_tick) begin
      n.rate_cnt = (q.rate_cnt == q.cfg[CFG_RATE_LSB +: 4]) ? 4'h0 : q.rate_cnt + 4'h1;
    end
    z_tick = q.ctrl[CTRL_VMODE_BIT] ? PWM_SAMPLE :
             (periph_tick & (q.rate_cnt == q.cfg[CFG_RATE_LSB +: 4]));

    // Edge classification against previous sample
    z_hit = q.cfg[CFG_POL_BIT] ? (cmp & ~q.prev_cmp) : (~cmp & q.prev_cmp);
    d_hit = (q.cfg[CFG_POL_BIT] ~^ q.cfg[CFG_ZVD_BIT]) ? (cmp & ~q.prev_cmp)
                                                       : (~cmp & q.prev_cmp);
    if ((q.state inside {ST_Z_BLANK, ST_Z_COUNT}) ? z_tick : d_tick) begin
      n.prev_cmp = cmp;
    end

    // Detection sequencer
    n.d_evt = 1'b0;
    n.z_evt = 1'b0;
    if (!active) begin
      n.state = ST_WAIT_C;
      n.cnt   = 5'h0;
    end else if (c_ev) begin
      // C restarts the D stage from any state
      n.state = sensor ? ST_D_COUNT : ST_D_BLANK;
      n.win   = win_ticks(q.dfilt[3:0]);
      n.cnt   = 5'h0;
    end else begin
      case (q.state)
        ST_WAIT_C: begin
          n.state = ST_WAIT_C;
        end
        ST_D_BLANK, ST_D_COUNT: begin
          if (sim_d) begin
            n.d_evt = 1'b1;
          end else if (q.state == ST_D_BLANK) begin
            if (periph_tick) begin
              n.win = q.win - 10'h1;
              if (q.win <= 10'h1) begin
                n.state = ST_D_COUNT;
              end
            end
          end else if (d_tick) begin
            n.cnt = d_hit ? q.cnt + 5'h1 : 5'h0;
            n.d_evt = d_hit & (q.cnt + 5'h1 >= d_lim);
          end
          if (n.d_evt) begin
            n.state = sensor ? ST_Z_COUNT : ST_Z_BLANK;
            n.win   = win_ticks(q.zfilt[3:0]);
            n.cnt   = 5'h0;
          end
        end
        ST_Z_BLANK, ST_Z_COUNT: begin
          if (sim_z) begin
            n.z_evt = 1'b1;
          end else if (q.state == ST_Z_BLANK) begin
            if (periph_tick) begin
              n.win = q.win - 10'h1;
              if (q.win <= 10'h1) begin
                n.state = ST_Z_COUNT;
              end
            end
          end else if (z_tick) begin
            n.cnt = z_hit ? q.cnt + 5'h1 : 5'h0;
            n.z_evt = z_hit & (q.cnt + 5'h1 >= z_lim);
          end
          if (n.z_evt) begin
            n.state = q.ctrl[CTRL_HARD_BIT] ? ST_WAIT_C : ST_Z_COUNT;
            n.cnt   = 5'h0;
          end
        end
        default: n.state = ST_WAIT_C;
      endcase
    end

    // Sticky flags, set wins over clear
    n.d_flag = n.d_flag | n.d_evt;
    n.z_flag = n.z_flag | n.z_evt;

    // Mode and analog control outputs
    n.comp_on = n.ctrl[CTRL_CKE_BIT] | n.ctrl[CTRL_DAC_BIT];
    n.speed   = n.cfg[CFG_TYPE_LSB +: 2] != TYPE_POS;
    n.ext_ref = n.cfg[CFG_THR_LSB +: 3] == THRESH_EXT;
  end

  //****************************************************************************
  // State register
  //****************************************************************************
  // Single register for all state
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q         <= '0;
      q.ctrl    <= CTRL_RST;
      q.cfg_pre <= CFG_RST;
      q.cfg     <= CFG_RST;
      q.dfilt   <= FILT_RST;
      q.zfilt   <= FILT_RST;
      q.state   <= ST_WAIT_C;
    end else begin
      q <= n;
    end
  end

  // Ports straight from the register
  assign PRDATA         = q.prdata;
  assign PREADY         = q.pready;
  assign PSLVERR        = q.pslverr;
  assign COMP_ON        = q.comp_on;
  assign PHASE_SEL      = q.cfg[CFG_SEL_LSB +: 2];
  assign THRESH_SEL     = q.cfg[CFG_THR_LSB +: 3];
  assign EXT_REF_SEL    = q.ext_ref;
  assign SPEED_MODE     = q.speed;
  assign DIGITAL_PHASES = q.lvl[2:0];
  assign D_EVENT        = q.d_evt;
  assign Z_EVENT        = q.z_evt;

  //****************************************************************************
  // Assertions
  //****************************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  comp_off_quiet_a: assert property (!$past(q.comp_on) |-> !q.d_evt && !q.z_evt)
    else $error("event while comparator off");
  cfg_preload_a: assert property (!$past(c_ev) && !$past(q.ctrl[CTRL_DAC_BIT]) |-> $stable(q.cfg))
    else $error("active config changed without C");
  d_blank_quiet_a: assert property (q.state == ST_D_BLANK && !sim_d && !c_ev |=> !q.d_evt)
    else $error("D accepted inside blanking window");
  d_win_load_a: assert property ($past(active) && $past(c_ev) && !$past(sensor) |->
                                 q.state == ST_D_BLANK && q.win == win_ticks($past(q.dfilt[3:0])))
    else $error("D window not loaded at C");
  sensor_no_blank_a: assert property ($past(active) && $past(c_ev) && $past(sensor) |-> q.state == ST_D_COUNT)
    else $error("blanking applied in sensor mode");
  z_order_a: assert property (q.z_evt && $past(q.ctrl[CTRL_HARD_BIT]) |->
                              $past(q.state) inside {ST_Z_BLANK, ST_Z_COUNT})
    else $error("Z out of order");
  d_count_a: assert property (q.d_evt && !$past(sim_d) |-> $past(q.cnt) + 5'h1 == $past(d_lim))
    else $error("D limit mismatch");
  z_count_a: assert property (q.z_evt && !$past(sim_z) |-> $past(q.cnt) + 5'h1 == $past(z_lim))
    else $error("Z limit mismatch");
  flag_set_a: assert property (q.d_evt |-> q.d_flag ##1 q.d_flag || $past(wr_done))
    else $error("D flag lost");
  speed_mode_a: assert property ($past(q.speed) |-> q.state == ST_WAIT_C && !q.d_evt)
    else $error("detection ran in speed mode");
  speed_decode_a: assert property (q.speed == (q.cfg[CFG_TYPE_LSB +: 2] != TYPE_POS))
    else $error("speed mode decode wrong");

  hw_d_c: cover property (q.state == ST_D_COUNT ##1 q.d_evt);
  hw_z_c: cover property (q.state == ST_Z_COUNT && q.cnt == 5'h1 ##1 q.z_evt);
  sim_d_c: cover property (sim_d && q.state == ST_D_BLANK ##1 q.d_evt);
  speed_c: cover property (q.speed && q.comp_on);

endmodule

//--- sim/bemfid_phase_model.sv
//******************************************************************************
// Motor phase windings seen through the threshold comparator
//******************************************************************************
// Purpose: Turns bench phase voltages (mV) into comparator and digital levels
// Assumes: Outputs change only after a rising SYS_CLK edge
// Notes:   External reference level is a plain default
`timescale 1ns/10ps

module bemfid_phase_model import bemfid_pkg::*; #(
  parameter int EXT_REF_MV = 1200
) (
  input  wire logic       clk,
  input  wire logic [1:0] phase_sel,
  input  wire logic [2:0] thresh_sel,
  input  var  int         mv [3],
  output logic            comp_out,
  output logic [2:0]      phase_lvl
);
  int ref_tab [8] = '{200, 600, 1000, 1500, 2000, 2500, 3500, 0};
  int ref_mv;

  //****************************************************************************
  // Comparator and digital levels
  //****************************************************************************
  // Known levels from time zero
  initial begin
    comp_out  = 1'b0;
    phase_lvl = 3'h0;
  end

  // Reference pick, external pin on the top code
  always_comb begin
    ref_mv = (thresh_sel == THRESH_EXT) ? EXT_REF_MV : ref_tab[thresh_sel];
  end

  // Selected winding against reference; digital levels on A, B and C as well
  always @(posedge clk) begin
    comp_out  <= (phase_sel < 2'h3) && (mv[phase_sel] > ref_mv);
    phase_lvl <= {mv[2] > 2500, mv[1] > 2500, mv[0] > 2500};
  end
endmodule

//--- sim/bemfid_top_tb.sv
//******************************************************************************
// BEMF event input detection - testbench
//******************************************************************************
// Purpose: APB setup, phase/threshold routing, D/Z windows and speed mode
// Assumes: PERIPH_DIV of 2, so a code 0 window lasts 40 cycles
// Notes:   Voltage-mode pacing strobe is tied low
`timescale 1ns/10ps

module bemfid_top_tb import bemfid_pkg::*;;
  localparam int DIV = 2;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, comp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  evt, lvl, dig, thr, exp_dig;
  logic [1:0]  sel, phase_sel, sel_prev;
  logic [2:0]  thr_x;
  logic        e, comp_on, ext_ref, speed, d_ev, z_ev;
  int          mv [3];
  int          err_total, n_compared, d_cnt, z_cnt, s;

  bemfid_top #(.PERIPH_DIV(DIV)) bemfid_top_inst (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COMP_OUT(comp), .PHASE_A(lvl[0]), .PHASE_B(lvl[1]), .PHASE_C(lvl[2]), .C_EVT(evt[0]),
    .PWM_SAMPLE(1'b0), .SIM_D(evt[1]), .SIM_Z(evt[2]), .COMP_ON(comp_on), .PHASE_SEL(phase_sel),
    .THRESH_SEL(thr), .EXT_REF_SEL(ext_ref), .SPEED_MODE(speed), .DIGITAL_PHASES(dig),
    .D_EVENT(d_ev), .Z_EVENT(z_ev));

  bemfid_phase_model bemfid_phase_model_inst (
    .clk(sys_clk), .phase_sel(phase_sel), .thresh_sel(thr), .mv(mv), .comp_out(comp), .phase_lvl(lvl));

  //****************************************************************************
  // Helpers
  //****************************************************************************
  // Window length in cycles for a window code
  function automatic int win_cyc(input int code);
    return (code < 8 ? WIN_FINE_STEP_US * (code + 1) : WIN_COARSE_BASE_US + WIN_COARSE_STEP_US * (code - 8))
           * PERIPH_CLK_MHZ * DIV;
  endfunction

  // Value compare with report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge; ready taken at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One-cycle event strobe: 0 commutation, 1 simulated D, 2 simulated Z
  task automatic pulse(input int k);
    evt <= 3'h1 << k;
    @(posedge sys_clk);
    evt <= 3'h0;
    @(posedge sys_clk);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Bounded wait for the next D or Z pulse
  task automatic wait_ev(input bit z, input int lim);
    s = z ? z_cnt : d_cnt;
    for (int i = 0; i < lim && (z ? z_cnt : d_cnt) == s; i++) @(posedge sys_clk);
  endtask

  task summarize;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  //****************************************************************************
  // Clock, event counters, watchdog
  //****************************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (d_ev === 1'b1) d_cnt++;
    if (z_ev === 1'b1) z_cnt++;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

  //****************************************************************************
  // Main sequence
  //****************************************************************************
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    evt = 3'h0; mv = '{0, 0, 0};
    s = $urandom(32'h946b);
    waitc(4);
    rst_b <= 1'b1;
    waitc(1);
    // Reset contents, unmapped place, comparator off
    apb(1'b0, ADDR_CTRL, 32'h0); chk(r, 32'h10);
    apb(1'b0, ADDR_DFILT, 32'h0); chk(r, 32'h0f);
    apb(1'b0, ADDR_ZFILT, 32'h0); chk(r, 32'h0f);
    apb(1'b0, 8'h18, 32'h0); chk({r[30:0], e}, 32'h1);
    chk(comp_on, 1'b0);
    pulse(1); pulse(2); waitc(3);
    chk(d_cnt + z_cnt, 0);
    // Enable with hard commutation, limit 4 for filter bypass checks
    apb(1'b1, ADDR_CTRL, 32'h11);
    apb(1'b1, ADDR_DFILT, 32'h30);
    apb(1'b1, ADDR_ZFILT, 32'h30);
    chk(comp_on, 1'b1);
    // Routing and threshold, applied only at commutation
    sel_prev = 2'h0;
    for (int i = 0; i < 8; i++) begin
      sel = 2'($urandom % 3);
      thr_x = (i == 0) ? 3'h7 : 3'($urandom % 8);
      apb(1'b1, ADDR_CFG, {27'h0, thr_x, sel});
      chk(phase_sel, sel_prev);
      pulse(0); waitc(2);
      chk(phase_sel, sel);
      chk(thr, thr_x);
      chk(ext_ref, thr_x == 3'h7);
      chk(speed, 1'b0);
      sel_prev = sel;
    end
    // Simulated events: order and filter bypass
    apb(1'b1, ADDR_CFG, 32'h0);
    pulse(0); pulse(2); waitc(3);
    chk(z_cnt, 0);
    s = d_cnt; pulse(1); waitc(3);
    chk(d_cnt, s + 1);
    waitc(win_cyc(0) + 10);
    s = z_cnt; pulse(2); waitc(3);
    chk(z_cnt, s + 1);
    // Hardware D and Z behind code 0 windows, limit 1
    apb(1'b1, ADDR_DFILT, 32'h00);
    apb(1'b1, ADDR_ZFILT, 32'h00);
    s = d_cnt; pulse(0); waitc(6);
    mv[0] <= 4000; waitc(8);
    mv[0] <= 0; waitc(win_cyc(0));
    chk(d_cnt, s);
    s = d_cnt; mv[0] <= 4000; wait_ev(1'b0, 20);
    chk(d_cnt, s + 1);
    waitc(6); mv[0] <= 0;
    waitc(6); mv[0] <= 4000;
    s = z_cnt; waitc(win_cyc(0));
    chk(z_cnt, s);
    mv[0] <= 0; wait_ev(1'b1, 20);
    chk(z_cnt, s + 1);
    // Sensor mode: no windows after C or D
    apb(1'b1, ADDR_CTRL, 32'h15);
    pulse(0); waitc(4);
    s = d_cnt; mv[0] <= 4000; wait_ev(1'b0, 12);
    chk(d_cnt, s + 1);
    waitc(4);
    s = z_cnt; mv[0] <= 0; wait_ev(1'b1, 14);
    chk(z_cnt, s + 1);
    // Sticky flags, then write one to clear
    apb(1'b0, ADDR_STAT, 32'h0); chk(r, 32'h0b);
    apb(1'b1, ADDR_STAT, 32'h3);
    apb(1'b0, ADDR_STAT, 32'h0); chk(r, 32'h08);
    // Speed sensor mode through direct access, phases as digital levels
    apb(1'b1, ADDR_CTRL, 32'h13);
    apb(1'b1, ADDR_CFG, 32'h80); waitc(3);
    chk(speed, 1'b1);
    for (int i = 0; i < 6; i++) begin
      exp_dig = 3'($urandom % 8);
      for (int k = 0; k < 3; k++) mv[k] <= exp_dig[k] ? 4000 : 0;
      waitc(8);
      chk(dig, exp_dig);
    end
    apb(1'b1, ADDR_CFG, 32'h0); waitc(3);
    chk(speed, 1'b0);
    summarize();
  end
endmodule
